// ### core/ssram_pkg.sv
// shared constants and types of the flow-through ssram command decoder
package ssram_pkg;

	// array geometry
	localparam int ADDR_W    = 21;
	localparam int DATA_W    = 32;
	localparam int STEP_W    = 2;
	localparam int BURST_LEN = 4;

	// burst address field: the low bits step, the rest stay fixed
	localparam int STEP_LSB = 0;
	localparam int STEP_MSB = STEP_W - 1;

	// reset and start values
	localparam logic [STEP_W-1:0] STEP_RESET = 2'h0;
	localparam logic [STEP_W-1:0] STEP_ONE   = 2'h1;

	// host-side gap before sleep, checked only by the host
	localparam int SLEEP_SETUP_CYCLES = 2;

	// kind of the cycle that follows a sampled command
	typedef enum logic [3:0] {
		CYC_IDLE   = 4'h1,
		CYC_READ   = 4'h2,
		CYC_WRITE  = 4'h4,
		CYC_DUMMYW = 4'h8
	} cycle_e;

endpackage

// ### core/burst_address_step.sv
// next burst address bits, linear or interleaved order
module burst_address_step
	import ssram_pkg::*;
(
	// burst start bits and step index
	input  wire logic [STEP_W-1:0] startBits,
	input  wire logic [STEP_W-1:0] stepIndex,
	// order select, high for interleaved
	input  wire logic              interleaved,
	// resulting low address bits
	output logic      [STEP_W-1:0] stepBits
);

	// shared decode of one burst position
	function automatic logic [STEP_W-1:0] burstPos(input logic [STEP_W-1:0] s,
		input logic [STEP_W-1:0] i, input logic il);
		logic [STEP_W-1:0] r;
		r = il ? (s ^ i) : STEP_W'(s + i);
		return r;
	endfunction

	// linear wraps modulo four, interleaved is start xor index
	always_comb begin
		stepBits = burstPos(startBits, stepIndex, interleaved);
	end

endmodule

// ### core/ssram_array.sv
// flip-flop storage with one write port and a registered read port
module ssram_array
	import ssram_pkg::*;
#(
	parameter int AW = ADDR_W,
	parameter int DW = DATA_W
) (
	// clock, reset, freeze
	input  wire logic          ref_clk,
	input  wire logic          rst_b,
	input  wire logic          clkEn,
	// write port
	input  wire logic          wrEn,
	input  wire logic [AW-1:0] wrAddr,
	input  wire logic [DW-1:0] wrData,
	// read port
	input  wire logic          rdEn,
	input  wire logic [AW-1:0] rdAddr,
	output logic      [DW-1:0] rdData_reg
);

	logic [DW-1:0] mem [2**AW];

	// contents are not reset, as in a real array
	always_ff @(posedge ref_clk) begin
		if (clkEn && wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	// read word lands right after the command edge: flow-through
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdData_reg <= '0;
		end else if (clkEn && rdEn) begin
			rdData_reg <= mem[rdAddr];
		end
	end

endmodule

// ### core/ssram_cmd_decode.sv
// command decoder and data-line control of a flow-through ssram
// Functional notes
// - all selects, load, read: start read burst
// - advance during read: next address, selects ignored
// - selected load with write, no flush: write
// - advance with flush low continues write burst
// - flush high makes a dummy write, tri-stated
// - write cycle tri-states every data driver
// - output enable gates drivers without clock
// - output enable masked during write cycles
// - read drives only when enabled and selected
// - reset leaves device deselected, lines tri-stated
// - any inactive select at load: standby
// - counter serves four accesses per load
// - order pin picks interleaved or linear step
// - power-off cuts drivers asynchronously, blocks commands after sync, contents may go
module ssram_cmd_decode
	import ssram_pkg::*;
#(
	parameter int AW = ADDR_W,
	parameter int DW = DATA_W
) (
	// clock, reset, freeze
	input  wire logic          ref_clk,
	input  wire logic          rst_b,
	input  wire logic          clkEn,
	// synchronous command pins
	input  wire logic          chip_select_first_n,
	input  wire logic          chip_select_second,
	input  wire logic          chip_select_third_n,
	input  wire logic          advance_or_load,
	input  wire logic          writeEnableN,
	input  wire logic          pipe_flush_dummy,
	input  wire logic          clock_enable_n,
	input  wire logic          sleep_request,
	input  wire logic [AW-1:0] address,
	// static burst order strap, high for interleaved
	input  wire logic          burstOrderInterleaved,
	// asynchronous pins
	input  wire logic          outputEnableN,
	input  wire logic          powerOffRequest,
	// data lines as three signals
	input  wire logic [DW-1:0] dqIn,
	output logic      [DW-1:0] dqOut,
	output logic               dqOeN,
	// status
	output logic               sleepActive_reg,
	output logic               burstActive_reg
);

	// registered cycle state and burst address
	cycle_e            cyc_reg, cyc_next;
	logic [AW-1:0]     base_reg;
	logic [STEP_W-1:0] step_reg, step_next;
	logic [AW-1:0]     wrAddr_reg;
	logic              powerOffMeta_reg, powerOffSync_reg;

	// combinational decode
	logic              selected, loadCmd, cmdTake, writeTake, readNext;
	logic [STEP_W-1:0] nextBits;
	logic [AW-1:0]     accessAddr;
	logic [DW-1:0]     rdWord;

	// every select at its active level or the device stays out
	assign selected = !chip_select_first_n && chip_select_second && !chip_select_third_n;
	assign loadCmd  = !advance_or_load;

	// a command counts only on an enabled, awake edge
	assign cmdTake = clkEn && !clock_enable_n && !sleepActive_reg
		&& !powerOffSync_reg;

	// write data sits on the lines in the cycle after its command
	assign writeTake = cmdTake && (cyc_reg == CYC_WRITE);

	// burst position for a continue
	burst_address_step u_step (
		.startBits   (base_reg[STEP_MSB:STEP_LSB]),
		.stepIndex   (STEP_W'(step_reg + STEP_ONE)),
		.interleaved (burstOrderInterleaved),
		.stepBits    (nextBits)
	);

	// external address on load, stepped burst address on advance
	always_comb begin
		if (loadCmd) begin
			accessAddr = address;
		end else begin
			accessAddr = {base_reg[AW-1:STEP_W], nextBits};
		end
	end

	// decide the kind of the coming cycle
	always_comb begin
		cyc_next  = cyc_reg;
		step_next = step_reg;
		if (cmdTake) begin
			if (loadCmd) begin
				step_next = STEP_RESET;
				if (!selected) begin
					cyc_next = CYC_IDLE;
				end else if (writeEnableN) begin
					cyc_next = CYC_READ;
				end else if (pipe_flush_dummy) begin
					cyc_next = CYC_DUMMYW;
				end else begin
					cyc_next = CYC_WRITE;
				end
			end else begin
				// advance: selects and write enable are ignored
				case (cyc_reg)
					CYC_IDLE: begin
						cyc_next = CYC_IDLE;
					end
					CYC_READ: begin
						cyc_next  = CYC_READ;
						step_next = STEP_W'(step_reg + STEP_ONE);
					end
					CYC_WRITE, CYC_DUMMYW: begin
						cyc_next  = pipe_flush_dummy ? CYC_DUMMYW : CYC_WRITE;
						step_next = STEP_W'(step_reg + STEP_ONE);
					end
					default: begin
						cyc_next = CYC_IDLE;
					end
				endcase
			end
		end else if (clkEn && (sleepActive_reg || powerOffSync_reg)) begin
			cyc_next = CYC_IDLE;
		end
	end

	assign readNext = cmdTake && (cyc_next == CYC_READ);

	// power-off level crosses into the clock domain first
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			powerOffMeta_reg <= 1'b0;
			powerOffSync_reg <= 1'b0;
		end else if (clkEn) begin
			powerOffMeta_reg <= powerOffRequest;
			powerOffSync_reg <= powerOffMeta_reg;
		end
	end

	// sleep request is a synchronous pin, sampled on every edge that clkEn enables
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sleepActive_reg <= 1'b0;
		end else if (clkEn) begin
			sleepActive_reg <= sleep_request;
		end
	end

	// cycle state; reset lands deselected
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cyc_reg <= CYC_IDLE;
		end else if (clkEn) begin
			cyc_reg <= cyc_next;
		end
	end

	// burst counter and base address, frozen by a stall
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			step_reg <= STEP_RESET;
			base_reg <= '0;
		end else if (cmdTake) begin
			step_reg <= step_next;
			if (loadCmd && selected) begin
				base_reg <= address;
			end
		end
	end

	// address of the pending write, consumed at the data edge
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			wrAddr_reg <= '0;
		end else if (cmdTake) begin
			wrAddr_reg <= accessAddr;
		end
	end

	// burst flag for software visibility of the decoder state
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			burstActive_reg <= 1'b0;
		end else if (clkEn) begin
			burstActive_reg <= (cyc_next != CYC_IDLE);
		end
	end

	// storage; a read of a word being written the same edge sees old data
	ssram_array #(
		.AW (AW),
		.DW (DW)
	) u_array (
		.ref_clk    (ref_clk),
		.rst_b      (rst_b),
		.clkEn      (clkEn),
		.wrEn       (writeTake),
		.wrAddr     (wrAddr_reg),
		.wrData     (dqIn),
		.rdEn       (readNext),
		.rdAddr     (accessAddr),
		.rdData_reg (rdWord)
	);

	assign dqOut = rdWord;

	// drivers on only in a read cycle; oe and power-off gate without a clock
	assign dqOeN = (cyc_reg != CYC_READ) || outputEnableN || powerOffRequest;

	// checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	sequence readLoad;
		cmdTake && loadCmd && selected && writeEnableN;
	endsequence

	sequence writeLoad;
		cmdTake && loadCmd && selected && !writeEnableN && !pipe_flush_dummy;
	endsequence

	sequence advanceRun;
		cmdTake && !loadCmd && (cyc_reg != CYC_IDLE);
	endsequence

	// a stall edge that sleep or power-off does not override
	sequence stallEdge;
		clkEn && clock_enable_n && !sleepActive_reg && !powerOffSync_reg;
	endsequence

	a_read_start: assert property (readLoad |=> cyc_reg == CYC_READ)
		else $error("read load did not start a read");

	a_read_continue: assert property (cmdTake && !loadCmd && cyc_reg == CYC_READ
		|=> cyc_reg == CYC_READ)
		else $error("read burst did not continue");

	a_write_data: assert property (
		writeLoad ##1 (cmdTake && !loadCmd && !pipe_flush_dummy) |=> cyc_reg == CYC_WRITE)
		else $error("write burst lost its write cycle");

	a_dummy_write: assert property (cmdTake && loadCmd && selected && !writeEnableN
		&& pipe_flush_dummy |=> cyc_reg == CYC_DUMMYW && dqOeN)
		else $error("dummy write not tri-stated");

	a_write_tristate: assert property (cyc_reg inside {CYC_WRITE, CYC_DUMMYW} |-> dqOeN)
		else $error("drivers on during a write cycle");

	a_read_drive: assert property (cyc_reg == CYC_READ && !outputEnableN
		&& !powerOffRequest |-> !dqOeN)
		else $error("read not driven with output enable active");

	a_deselect_idle: assert property (cmdTake && loadCmd && !selected
		|=> cyc_reg == CYC_IDLE && dqOeN)
		else $error("partial select did not enter standby");

	a_idle_advance: assert property (cmdTake && !loadCmd && cyc_reg == CYC_IDLE
		|=> cyc_reg == CYC_IDLE && dqOeN)
		else $error("continue deselect left standby");

	a_load_base: assert property (cmdTake && loadCmd && selected
		|=> base_reg == $past(address) && step_reg == STEP_RESET)
		else $error("load did not take the external address");

	a_step_linear: assert property (advanceRun && !burstOrderInterleaved
		|-> accessAddr == {base_reg[AW-1:STEP_W],
		STEP_W'(base_reg[STEP_MSB:STEP_LSB] + step_reg + 1)})
		else $error("linear burst address wrong");

	a_step_interleave: assert property (advanceRun && burstOrderInterleaved
		|-> accessAddr[STEP_MSB:STEP_LSB]
		== (base_reg[STEP_MSB:STEP_LSB] ^ STEP_W'(step_reg + 1)))
		else $error("interleaved burst address wrong");

	a_burst_step: assert property (advanceRun |=> step_reg == STEP_W'($past(step_reg) + 1))
		else $error("burst counter did not step");

	a_burst_wrap: assert property (readLoad ##1 advanceRun [*3] |=> step_reg == 2'h3)
		else $error("four-access burst position wrong");

	a_stall_hold: assert property (stallEdge
		|=> $stable(cyc_reg) && $stable(step_reg) && $stable(base_reg))
		else $error("stall changed decoder state");

	a_freeze_hold: assert property (!clkEn
		|=> $stable(cyc_reg) && $stable(step_reg) && $stable(sleepActive_reg)
		&& $stable(burstActive_reg))
		else $error("frozen clock changed decoder state");

	a_sleep_entry: assert property (clkEn && sleep_request |=> sleepActive_reg)
		else $error("sleep request not taken");

	a_status_burst: assert property (clkEn
		|=> burstActive_reg == (cyc_reg != CYC_IDLE))
		else $error("burst flag disagrees with decoder state");

	a_sleep_quiet: assert property (sleepActive_reg && clkEn |=> cyc_reg == CYC_IDLE && dqOeN)
		else $error("sleep left the device active");

	a_poweroff_async: assert property (powerOffRequest |-> dqOeN)
		else $error("drivers on during power-off");

endmodule

// ### testbench/ssram_host_model.sv
// host memory controller model driving the ssram command pins
module ssram_host_model
	import ssram_pkg::*;
(
	// clock
	input  wire logic              ref_clk,
	// command pins
	output logic                   csFirstN,
	output logic                   csSecond,
	output logic                   csThirdN,
	output logic                   advLoad,
	output logic                   weN,
	output logic                   flush,
	output logic                   cenN,
	output logic                   sleepReq,
	output logic      [ADDR_W-1:0] addr,
	// write data toward the device
	output logic      [DATA_W-1:0] dIn
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle bus at time zero: continue deselect
	initial begin
		csFirstN = 1'b0;
		csSecond = 1'b0;
		csThirdN = 1'b0;
		advLoad  = 1'b1;
		weN      = 1'b1;
		flush    = 1'b0;
		cenN     = 1'b0;
		sleepReq = 1'b0;
		addr     = '0;
		dIn      = '0;
	end

	// one command {select, advance, we_n, flush, stall}, held a full cycle
	task automatic cyc(input logic [4:0] c, input logic [ADDR_W-1:0] a,
		input logic dv, input logic [DATA_W-1:0] d);
		@(posedge ref_clk);
		csSecond <= c[4];
		advLoad  <= c[3];
		weN      <= c[2];
		flush    <= c[1];
		cenN     <= c[0];
		addr     <= a;
		// released lines show the inverse, never a stale copy
		dIn      <= dv ? d : ~dIn;
	endtask

	// deselect for the setup gap, then ask for sleep
	task automatic doze();
		repeat (SLEEP_SETUP_CYCLES + 1) cyc(5'h04, '0, 1'b0, '0);
		@(posedge ref_clk);
		sleepReq <= 1'b1;
	endtask

	// leave sleep, still deselected
	task automatic wake();
		@(posedge ref_clk);
		sleepReq <= 1'b0;
	endtask
endmodule

// ### testbench/ssram_cmd_decode_test.sv
// self-checking bench of the ssram command decoder
module ssram_cmd_decode_test
	import ssram_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ns;

	// command codes {select, advance, we_n, flush, stall}
	localparam logic [4:0] LD_WR  = 5'h10;
	localparam logic [4:0] LD_RD  = 5'h14;
	localparam logic [4:0] ADV    = 5'h1c;
	localparam logic [4:0] STALL  = 5'h1d;
	localparam logic [4:0] LD_DW  = 5'h12;
	localparam logic [4:0] ADV_DW = 5'h1e;
	localparam logic [4:0] DESEL  = 5'h04;

	// stimulus, observation and bookkeeping
	logic              ref_clk = 1'b0;
	logic              rst_b = 1'b0;
	logic              oeN = 1'b0;
	logic              powerOff = 1'b0;
	logic              interleave = 1'b0;
	logic              clkEn = 1'b1;
	logic              csFirstN, csSecond, csThirdN, advLoad, weN, flush, cenN, sleepReq;
	logic              dqOeN, sleepActive, burstActive;
	logic [ADDR_W-1:0] addr;
	logic [ADDR_W-1:0] base;
	logic [DATA_W-1:0] dIn;
	logic [DATA_W-1:0] dqOut;
	logic [DATA_W-1:0] d [4];
	logic [DATA_W-1:0] expQ [$];
	int                n_errors = 0;
	int                total_checks = 0;
	int                cycles = 0;
	int                seed = 23311;

	// 100 MHz clock
	always #5 ref_clk = ~ref_clk;

	ssram_host_model u_host (
		.ref_clk(ref_clk), .csFirstN(csFirstN), .csSecond(csSecond), .csThirdN(csThirdN),
		.advLoad(advLoad), .weN(weN), .flush(flush), .cenN(cenN), .sleepReq(sleepReq),
		.addr(addr), .dIn(dIn)
	);

	ssram_cmd_decode u_dut (
		.ref_clk(ref_clk), .rst_b(rst_b), .clkEn(clkEn),
		.chip_select_first_n(csFirstN), .chip_select_second(csSecond),
		.chip_select_third_n(csThirdN), .advance_or_load(advLoad), .writeEnableN(weN),
		.pipe_flush_dummy(flush), .clock_enable_n(cenN), .sleep_request(sleepReq),
		.address(addr), .burstOrderInterleaved(interleave), .outputEnableN(oeN),
		.powerOffRequest(powerOff), .dqIn(dIn), .dqOut(dqOut), .dqOeN(dqOeN),
		.sleepActive_reg(sleepActive), .burstActive_reg(burstActive)
	);

	// compare and count
	task automatic chk(input string what, input logic [DATA_W-1:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// driver enable, looked at once the edge has settled
	task automatic chkOe(input logic e);
		#1;
		chk("dqOeN", DATA_W'(dqOeN), DATA_W'(e));
	endtask

	task automatic conclude();
		if (n_errors == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// oldest note is taken whenever the device drives the lines
	always @(negedge ref_clk) begin
		if (dqOeN === 1'b0) begin
			if (expQ.size() == 0) chk("unexpected drive", '0, '1);
			else chk("dqOut", dqOut, expQ.pop_front());
		end
	end

	// hang guard, far above the few dozen cycles needed
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 400) begin
			n_errors++;
			conclude();
		end
	end

	initial begin
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'b1;
		chkOe(1'b1);
		chk("burstActive", DATA_W'(burstActive), '0);
		base = ADDR_W'($random(seed));
		base[1:0] = 2'h0;
		foreach (d[i]) d[i] = $random(seed);
		// linear write burst of four, output enable held active
		u_host.cyc(LD_WR, base, 1'b0, '0);
		for (int i = 0; i < 3; i++) begin
			u_host.cyc(ADV, '0, 1'b1, d[i]);
			chkOe(1'b1);
		end
		chk("burstActive", DATA_W'(burstActive), DATA_W'(1'b1));
		// interleaved read from step 01 while the last word lands
		interleave <= 1'b1;
		u_host.cyc(LD_RD, {base[ADDR_W-1:2], 2'h1}, 1'b1, d[3]);
		expQ.push_back(d[1]);
		u_host.cyc(ADV, '0, 1'b0, '0);
		expQ.push_back(d[0]);
		u_host.cyc(STALL, '0, 1'b0, '0);
		@(posedge ref_clk);
		#2 oeN = 1'b1;
		chkOe(1'b1);
		@(negedge ref_clk);
		#1 oeN = 1'b0;
		expQ.push_back(d[0]);
		u_host.cyc(ADV, '0, 1'b0, '0);
		expQ.push_back(d[3]);
		u_host.cyc(ADV, '0, 1'b0, '0);
		expQ.push_back(d[2]);
		// one select dropped at a load, then continue deselect
		u_host.cyc(DESEL, base, 1'b0, '0);
		u_host.cyc(ADV, '0, 1'b0, '0);
		chkOe(1'b1);
		chk("burstActive", DATA_W'(burstActive), '0);
		// dummy write over word zero must leave it intact
		u_host.cyc(LD_DW, base, 1'b0, '0);
		u_host.cyc(ADV_DW, '0, 1'b1, ~d[0]);
		chkOe(1'b1);
		u_host.cyc(LD_RD, base, 1'b1, ~d[1]);
		expQ.push_back(d[0]);
		u_host.cyc(DESEL, base, 1'b0, '0);
		// sleep keeps lines off with output enable active
		u_host.doze();
		repeat (2) @(posedge ref_clk);
		chkOe(1'b1);
		chk("sleepActive", DATA_W'(sleepActive), DATA_W'(1'b1));
		// frozen clock must hold the sleep flag past the wake request
		clkEn <= 1'b0;
		u_host.wake();
		@(posedge ref_clk);
		clkEn <= 1'b1;
		#1;
		chk("frozen sleepActive", DATA_W'(sleepActive), DATA_W'(1'b1));
		u_host.cyc(DESEL, base, 1'b0, '0);
		// linear read from step 01: three words, then power-off cuts the fourth
		interleave <= 1'b0;
		u_host.cyc(LD_RD, {base[ADDR_W-1:2], 2'h1}, 1'b0, '0);
		expQ.push_back(d[1]);
		for (int i = 2; i < 4; i++) begin
			u_host.cyc(ADV, '0, 1'b0, '0);
			expQ.push_back(d[i]);
		end
		u_host.cyc(ADV, '0, 1'b0, '0);
		@(posedge ref_clk);
		#2 powerOff = 1'b1;
		chkOe(1'b1);
		chk("notes left", DATA_W'(expQ.size()), '0);
		// let the wrap check of the four-word burst see its edge
		repeat (2) @(posedge ref_clk);
		conclude();
	end
endmodule
